// File: design/cbx_exec.sv
// Execution sequencer for branches, bit operations and data transfers
`include "cbx_params.svh"
module cbx_exec
  import cbx_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // Instruction command
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire cbx_op_e     CMD_OP,
  input  wire logic [7:0]  CMD_REG_VAL,
  input  wire logic [2:0]  CMD_BIT,
  input  wire logic [6:0]  CMD_OFFSET,
  input  wire cbx_ptr_e    CMD_PTR,
  input  wire cbx_amode_e  CMD_AMODE,
  input  wire logic [5:0]  CMD_DISP,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [4:0]  CMD_IO_ADDR,
  // Shared state loads from neighbouring sections
  input  wire logic        PC_LOAD,
  input  wire logic [15:0] PC_LOAD_VAL,
  input  wire logic        FLAGS_LOAD,
  input  wire logic [7:0]  FLAGS_LOAD_VAL,
  input  wire logic        PTR_LOAD,
  input  wire cbx_ptr_e    PTR_LOAD_SEL,
  input  wire logic [15:0] PTR_LOAD_VAL,
  // Architectural state
  output logic [15:0]      PC,
  output logic [7:0]       FLAGS,
  output logic [15:0]      X_PTR,
  output logic [15:0]      Y_PTR,
  output logic [15:0]      Z_PTR,
  // Register write-back
  output logic             RES_VALID,
  output logic [7:0]       RES_VAL,
  // Data memory
  output logic             DM_REQ,
  output logic             DM_WE,
  output logic [15:0]      DM_ADDR,
  output logic [7:0]       DM_WDATA,
  input  wire logic [7:0]  DM_RDATA,
  // I/O space
  output logic             IO_RD,
  output logic             IO_WE,
  output logic [4:0]       IO_ADDR,
  output logic [7:0]       IO_WDATA,
  input  wire logic [7:0]  IO_RDATA,
  // Program memory
  output logic             PM_REQ,
  output logic [14:0]      PM_ADDR,
  input  wire logic [15:0] PM_RDATA
);
  // State registers
  cbx_state_e  state_reg;                    // Sequencer state
  logic [15:0] pc_reg;                       // Program counter
  logic [7:0]  flags_reg;                    // status_flags_reg
  logic [15:0] ptr_reg [0:2];                // X, Y, Z pointer pairs
  logic [1:0]  pm_cnt_reg;                   // Program memory wait count
  logic        pm_byte_reg;                  // Z bit 0 of the access
  logic [2:0]  io_bit_reg;                   // Bit under I/O update
  logic        io_set_reg;                   // Set or clear form
  logic        res_valid_reg;
  logic [7:0]  res_val_reg;
  logic        dm_req_reg, dm_we_reg;
  logic [15:0] dm_addr_reg;
  logic [7:0]  dm_wdata_reg;
  logic        io_rd_reg, io_we_reg;
  logic [4:0]  io_addr_reg;
  logic [7:0]  io_wdata_reg;
  logic        pm_req_reg;
  logic [14:0] pm_addr_reg;

  // Combinational helpers
  logic        accept;                       // Command taken this edge
  logic        is_branch, br_taken;
  logic [7:0]  bit_res, bit_flags;
  logic        bit_wr;
  logic        ptr_op;                       // Pointer-addressed access
  logic [15:0] cur_ptr;                      // Selected pointer value
  logic [15:0] ptr_next;                     // Pointer after step
  logic [15:0] eff_addr;                     // Data address of access

  // Sign-extend a 7-bit word offset
  function automatic logic [15:0] sext7(input logic [6:0] k);
    return {{9{k[6]}}, k};
  endfunction : sext7

  // Pointer step for the addressing mode, wrapping at 16 bits
  function automatic logic [15:0] step_ptr(input logic [15:0] p, input cbx_amode_e m);
    case (m)
      AM_POSTINC: return p + 16'h0001;
      AM_PREDEC:  return p - 16'h0001;
      default:    return p;
    endcase
  endfunction : step_ptr

  assign accept  = CMD_VALID && (state_reg == ST_IDLE);
  assign CMD_READY = (state_reg == ST_IDLE);
  assign cur_ptr = ptr_reg[CMD_PTR];
  assign ptr_op  = (CMD_OP == OP_LOAD_INDIRECT) || (CMD_OP == OP_STORE_INDIRECT);
  assign ptr_next = step_ptr(cur_ptr, CMD_AMODE);

  // Effective data address per addressing form
  always_comb begin
    case (CMD_AMODE)
      AM_PREDEC: eff_addr = ptr_next;
      AM_DISP:   eff_addr = cur_ptr + {10'h000, CMD_DISP};
      default:   eff_addr = cur_ptr;
    endcase
    if ((CMD_OP == OP_LOAD_DIRECT) || (CMD_OP == OP_STORE_DIRECT)) begin
      eff_addr = CMD_ADDR;
    end
  end

  // Branch condition on flags left by the previous instruction
  cbx_branch_cond u_cond (
    .op        (CMD_OP),
    .flags     (flags_reg),
    .is_branch (is_branch),
    .taken     (br_taken)
  );

  // Shift, swap and bit transfer datapath
  cbx_bit_unit u_bits (
    .op            (CMD_OP),
    .operand       (CMD_REG_VAL),
    .bit_sel       (CMD_BIT),
    .flags         (flags_reg),
    .result        (bit_res),
    .writes_result (bit_wr),
    .flags_out     (bit_flags)
  );

  // Sequencer: extra cycles for taken branches, memory, I/O, program memory
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= ST_IDLE;
      pm_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            if (is_branch && br_taken) begin
              state_reg <= ST_BR_WAIT;
            end else if (ptr_op || (CMD_OP == OP_LOAD_DIRECT)
                         || (CMD_OP == OP_STORE_DIRECT)) begin
              state_reg <= ST_MEM;
            end else if ((CMD_OP == OP_IO_BIT_SET) || (CMD_OP == OP_IO_BIT_CLEAR)) begin
              state_reg <= ST_IO;
            end else if (CMD_OP == OP_PROGRAM_MEM_LOAD) begin
              state_reg  <= ST_PM;
              pm_cnt_reg <= 2'(`CBX_CYC_PM - 2);
            end
          end
        end
        ST_PM: begin
          // Count down the program memory wait
          if (pm_cnt_reg == 2'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            pm_cnt_reg <= pm_cnt_reg - 2'h1;
          end
        end
        ST_BR_WAIT, ST_MEM, ST_IO: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Program counter: relative jump or step past the instruction
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_reg <= `CBX_RST_PC;
    end else if (PC_LOAD) begin
      pc_reg <= PC_LOAD_VAL;
    end else if (accept) begin
      if (is_branch && br_taken) begin
        pc_reg <= pc_reg + sext7(CMD_OFFSET) + `CBX_PC_STEP1;
      end else if ((CMD_OP == OP_LOAD_DIRECT) || (CMD_OP == OP_STORE_DIRECT)) begin
        pc_reg <= pc_reg + `CBX_PC_STEP2;                   // Two-word instruction
      end else begin
        pc_reg <= pc_reg + `CBX_PC_STEP1;
      end
    end
  end

  // Status flags: branches, memory and I/O forms leave them alone
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_reg <= `CBX_RST_FLAGS;
    end else if (FLAGS_LOAD) begin
      flags_reg <= FLAGS_LOAD_VAL;
    end else if (accept) begin
      case (CMD_OP)
        OP_FLAG_SET_INDEXED:   flags_reg[CMD_BIT] <= 1'b1;
        OP_FLAG_CLEAR_INDEXED: flags_reg[CMD_BIT] <= 1'b0;
        default:               flags_reg <= bit_flags;
      endcase
    end
  end

  // Pointer pairs: external load wins, else post-inc or pre-dec step
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        ptr_reg[i] <= `CBX_RST_PTR;
      end
    end else if (PTR_LOAD) begin
      ptr_reg[PTR_LOAD_SEL] <= PTR_LOAD_VAL;
    end else if (accept && ptr_op) begin
      ptr_reg[CMD_PTR] <= ptr_next;
    end else if (accept && (CMD_OP == OP_PROGRAM_MEM_LOAD)) begin
      ptr_reg[PTR_Z] <= step_ptr(ptr_reg[PTR_Z], CMD_AMODE);
    end
  end

  // Data memory request, held for the one memory cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dm_req_reg   <= 1'b0;
      dm_we_reg    <= 1'b0;
      dm_addr_reg  <= 16'h0000;
      dm_wdata_reg <= 8'h00;
    end else if (accept && (ptr_op || (CMD_OP == OP_LOAD_DIRECT)
                            || (CMD_OP == OP_STORE_DIRECT))) begin
      dm_req_reg   <= 1'b1;
      dm_we_reg    <= (CMD_OP == OP_STORE_INDIRECT) || (CMD_OP == OP_STORE_DIRECT);
      dm_addr_reg  <= eff_addr;
      dm_wdata_reg <= CMD_REG_VAL;
    end else begin
      dm_req_reg <= 1'b0;
      dm_we_reg  <= 1'b0;
    end
  end

  // I/O read in the first cycle, bit write-back in the next
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      io_rd_reg    <= 1'b0;
      io_we_reg    <= 1'b0;
      io_addr_reg  <= 5'h00;
      io_wdata_reg <= 8'h00;
      io_bit_reg   <= 3'h0;
      io_set_reg   <= 1'b0;
    end else begin
      io_we_reg <= 1'b0;
      io_rd_reg <= 1'b0;
      if (accept && ((CMD_OP == OP_IO_BIT_SET) || (CMD_OP == OP_IO_BIT_CLEAR))) begin
        io_rd_reg   <= 1'b1;
        io_addr_reg <= CMD_IO_ADDR;
        io_bit_reg  <= CMD_BIT;
        io_set_reg  <= (CMD_OP == OP_IO_BIT_SET);
      end else if (state_reg == ST_IO) begin
        // Only the addressed bit changes; the rest is read back
        io_we_reg    <= 1'b1;
        io_wdata_reg <= IO_RDATA;
        io_wdata_reg[io_bit_reg] <= io_set_reg;
      end
    end
  end

  // Program memory address is the word holding the Z byte
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pm_req_reg  <= 1'b0;
      pm_addr_reg <= 15'h0000;
      pm_byte_reg <= 1'b0;
    end else if (accept && (CMD_OP == OP_PROGRAM_MEM_LOAD)) begin
      pm_req_reg  <= 1'b1;
      pm_addr_reg <= ptr_reg[PTR_Z][15:1];
      pm_byte_reg <= ptr_reg[PTR_Z][0];
    end else if ((state_reg == ST_PM) && (pm_cnt_reg == 2'h0)) begin
      pm_req_reg <= 1'b0;
    end
  end

  // Register write-back: one-cycle pulse with the result byte
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      res_valid_reg <= 1'b0;
      res_val_reg   <= 8'h00;
    end else begin
      res_valid_reg <= 1'b0;
      if (accept && bit_wr) begin
        res_valid_reg <= 1'b1;
        res_val_reg   <= bit_res;
      end else if ((state_reg == ST_MEM) && !dm_we_reg) begin
        res_valid_reg <= 1'b1;
        res_val_reg   <= DM_RDATA;
      end else if ((state_reg == ST_PM) && (pm_cnt_reg == 2'h0)) begin
        res_valid_reg <= 1'b1;
        res_val_reg   <= pm_byte_reg ? PM_RDATA[15:8] : PM_RDATA[7:0];
      end
    end
  end

  // Output mapping
  assign PC        = pc_reg;
  assign FLAGS     = flags_reg;
  assign X_PTR     = ptr_reg[PTR_X];
  assign Y_PTR     = ptr_reg[PTR_Y];
  assign Z_PTR     = ptr_reg[PTR_Z];
  assign RES_VALID = res_valid_reg;
  assign RES_VAL   = res_val_reg;
  assign DM_REQ    = dm_req_reg;
  assign DM_WE     = dm_we_reg;
  assign DM_ADDR   = dm_addr_reg;
  assign DM_WDATA  = dm_wdata_reg;
  assign IO_RD     = io_rd_reg;
  assign IO_WE     = io_we_reg;
  assign IO_ADDR   = io_addr_reg;
  assign IO_WDATA  = io_wdata_reg;
  assign PM_REQ    = pm_req_reg;
  assign PM_ADDR   = pm_addr_reg;

  // Checks, quiet only when no shared-state load interferes
  logic quiet;
  assign quiet = !PC_LOAD && !FLAGS_LOAD && !PTR_LOAD;

  property p_br_untaken;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && is_branch && !br_taken |=> CMD_READY;
  endproperty
  a_br_untaken: assert property (p_br_untaken) else $error("untaken branch stalled");

  property p_br_taken;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && is_branch && br_taken |=> !CMD_READY ##1 CMD_READY;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch not two cycles");

  property p_br_target;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && is_branch && br_taken && quiet
      |=> PC == $past(pc_reg) + sext7($past(CMD_OFFSET)) + 16'h0001;
  endproperty
  a_br_target: assert property (p_br_target) else $error("branch target wrong");

  property p_br_flags;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && is_branch && quiet |=> $stable(FLAGS);
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("branch altered flags");

  property p_swap;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && (CMD_OP == OP_NIBBLE_SWAP) && quiet
      |=> RES_VALID && (RES_VAL == {$past(CMD_REG_VAL[3:0]), $past(CMD_REG_VAL[7:4])})
          && $stable(FLAGS);
  endproperty
  a_swap: assert property (p_swap) else $error("swap result or flags wrong");

  property p_load_two;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && (CMD_OP == OP_LOAD_INDIRECT)
      |=> DM_REQ && !DM_WE && !CMD_READY ##1 RES_VALID && CMD_READY;
  endproperty
  a_load_two: assert property (p_load_two) else $error("indirect load timing wrong");

  property p_predec;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && ptr_op && (CMD_AMODE == AM_PREDEC) && quiet
      |=> DM_ADDR == $past(cur_ptr) - 16'h0001;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement address wrong");

  property p_disp_keep;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && ptr_op && (CMD_AMODE == AM_DISP) && quiet
      |=> (DM_ADDR == $past(cur_ptr) + {10'h000, $past(CMD_DISP)}) && $stable(Z_PTR)
          && $stable(Y_PTR);
  endproperty
  a_disp_keep: assert property (p_disp_keep) else $error("displaced access moved pointer");

  property p_io_bit;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && (CMD_OP == OP_IO_BIT_SET)
      |=> IO_RD ##1 IO_WE && IO_WDATA[io_bit_reg];
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("I/O bit not set");

  property p_pm_three;
    @(posedge CORE_CLK) disable iff (!RST_N)
      accept && (CMD_OP == OP_PROGRAM_MEM_LOAD)
      |=> !CMD_READY ##1 !CMD_READY ##1 CMD_READY && RES_VALID;
  endproperty
  a_pm_three: assert property (p_pm_three) else $error("program load not three cycles");
endmodule : cbx_exec

// File: design/cbx_params.svh
// Constants of the branch, bit and transfer execution block
`ifndef CBX_PARAMS_SVH
`define CBX_PARAMS_SVH
// Status flag bit positions
`define CBX_FLAG_C 3'd0
`define CBX_FLAG_Z 3'd1
`define CBX_FLAG_N 3'd2
`define CBX_FLAG_V 3'd3
`define CBX_FLAG_S 3'd4
`define CBX_FLAG_H 3'd5
`define CBX_FLAG_T 3'd6
`define CBX_FLAG_I 3'd7
// Reset values
`define CBX_RST_FLAGS 8'h00
`define CBX_RST_PC    16'h0000
`define CBX_RST_PTR   16'h0000
// Cycle counts per instruction class
`define CBX_CYC_SINGLE 1
`define CBX_CYC_BR_TAKEN 2
`define CBX_CYC_MEM 2
`define CBX_CYC_PM 3
// Program counter step for one- and two-word instructions
`define CBX_PC_STEP1 16'h0001
`define CBX_PC_STEP2 16'h0002
`endif

// File: design/cbx_pkg.sv
// Types shared by the branch, bit and transfer execution block
package cbx_pkg;
  // Decoded instruction handed to the block
  typedef enum logic [4:0] {
    OP_NOP                          = 5'h00,
    OP_BRANCH_SIGNED_LESS           = 5'h01,
    OP_BRANCH_SIGNED_GREATER_EQUAL  = 5'h02,
    OP_BRANCH_HALFCARRY_SET         = 5'h03,
    OP_BRANCH_HALFCARRY_CLEAR       = 5'h04,
    OP_BRANCH_TRANSFER_SET          = 5'h05,
    OP_BRANCH_TRANSFER_CLEAR        = 5'h06,
    OP_BRANCH_OVERFLOW_SET          = 5'h07,
    OP_BRANCH_OVERFLOW_CLEAR        = 5'h08,
    OP_BRANCH_IRQ_ENABLED           = 5'h09,
    OP_BRANCH_IRQ_DISABLED          = 5'h0a,
    OP_IO_BIT_SET                   = 5'h0b,
    OP_IO_BIT_CLEAR                 = 5'h0c,
    OP_SHIFT_LEFT_LOGICAL           = 5'h0d,
    OP_ROTATE_LEFT_CARRY            = 5'h0e,
    OP_SHIFT_RIGHT_LOGICAL          = 5'h0f,
    OP_ROTATE_RIGHT_CARRY           = 5'h10,
    OP_SHIFT_RIGHT_ARITH            = 5'h11,
    OP_NIBBLE_SWAP                  = 5'h12,
    OP_FLAG_SET_INDEXED             = 5'h13,
    OP_FLAG_CLEAR_INDEXED           = 5'h14,
    OP_BIT_TO_TRANSFER              = 5'h15,
    OP_TRANSFER_TO_BIT              = 5'h16,
    OP_LOAD_INDIRECT                = 5'h17,
    OP_STORE_INDIRECT               = 5'h18,
    OP_LOAD_DIRECT                  = 5'h19,
    OP_STORE_DIRECT                 = 5'h1a,
    OP_PROGRAM_MEM_LOAD             = 5'h1b
  } cbx_op_e;
  // Pointer pair selection
  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } cbx_ptr_e;
  // Pointer addressing mode
  typedef enum logic [1:0] {
    AM_PLAIN   = 2'h0,
    AM_POSTINC = 2'h1,
    AM_PREDEC  = 2'h2,
    AM_DISP    = 2'h3
  } cbx_amode_e;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_BR_WAIT = 5'b00010,
    ST_MEM     = 5'b00100,
    ST_IO      = 5'b01000,
    ST_PM      = 5'b10000
  } cbx_state_e;
endpackage : cbx_pkg

// File: design/cbx_branch_cond.sv
// Condition evaluation for the flag branches
`include "cbx_params.svh"
module cbx_branch_cond
  import cbx_pkg::*;
(
  // Decoded instruction and flags
  input  wire cbx_op_e    op,
  input  wire logic [7:0] flags,
  // Evaluation result
  output logic            is_branch,
  output logic            taken
);
  // Flag bits picked out once
  logic n_f, v_f, h_f, t_f, i_f;
  assign n_f = flags[`CBX_FLAG_N];
  assign v_f = flags[`CBX_FLAG_V];
  assign h_f = flags[`CBX_FLAG_H];
  assign t_f = flags[`CBX_FLAG_T];
  assign i_f = flags[`CBX_FLAG_I];

  // Condition per branch form
  always_comb begin
    is_branch = 1'b1;
    taken     = 1'b0;
    case (op)
      OP_BRANCH_SIGNED_LESS:          taken = n_f ^ v_f;
      OP_BRANCH_SIGNED_GREATER_EQUAL: taken = ~(n_f ^ v_f);
      OP_BRANCH_HALFCARRY_SET:        taken = h_f;
      OP_BRANCH_HALFCARRY_CLEAR:      taken = ~h_f;
      OP_BRANCH_TRANSFER_SET:         taken = t_f;
      OP_BRANCH_TRANSFER_CLEAR:       taken = ~t_f;
      OP_BRANCH_OVERFLOW_SET:         taken = v_f;
      OP_BRANCH_OVERFLOW_CLEAR:       taken = ~v_f;
      OP_BRANCH_IRQ_ENABLED:          taken = i_f;
      OP_BRANCH_IRQ_DISABLED:         taken = ~i_f;
      default:                        is_branch = 1'b0;
    endcase
  end
endmodule : cbx_branch_cond

// File: design/cbx_bit_unit.sv
// Shift, rotate, swap and bit-transfer datapath
`include "cbx_params.svh"
module cbx_bit_unit
  import cbx_pkg::*;
(
  // Operands
  input  wire cbx_op_e    op,
  input  wire logic [7:0] operand,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] flags,
  // Results
  output logic [7:0]      result,
  output logic            writes_result,
  output logic [7:0]      flags_out
);
  // Carry-out and result before flag derivation
  logic       c_new;
  logic       shift_op;
  logic       n_new;

  // Datapath per operation
  always_comb begin
    result        = operand;
    writes_result = 1'b1;
    shift_op      = 1'b1;
    c_new         = flags[`CBX_FLAG_C];
    case (op)
      OP_SHIFT_LEFT_LOGICAL: begin
        result = {operand[6:0], 1'b0};
        c_new  = operand[7];
      end
      OP_ROTATE_LEFT_CARRY: begin
        result = {operand[6:0], flags[`CBX_FLAG_C]};
        c_new  = operand[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        result = {1'b0, operand[7:1]};
        c_new  = operand[0];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        result = {flags[`CBX_FLAG_C], operand[7:1]};
        c_new  = operand[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        result = {operand[7], operand[7:1]};
        c_new  = operand[0];
      end
      OP_NIBBLE_SWAP: begin
        result   = {operand[3:0], operand[7:4]};
        shift_op = 1'b0;
      end
      OP_TRANSFER_TO_BIT: begin
        result          = operand;
        result[bit_sel] = flags[`CBX_FLAG_T];
        shift_op        = 1'b0;
      end
      default: begin
        writes_result = 1'b0;
        shift_op      = 1'b0;
      end
    endcase
  end

  // Flag update: shifts touch Z, C, N, V only
  assign n_new = result[7];
  always_comb begin
    flags_out = flags;
    if (shift_op) begin
      flags_out[`CBX_FLAG_Z] = (result == 8'h00);
      flags_out[`CBX_FLAG_C] = c_new;
      flags_out[`CBX_FLAG_N] = n_new;
      flags_out[`CBX_FLAG_V] = n_new ^ c_new;
    end else if (op == OP_BIT_TO_TRANSFER) begin
      flags_out[`CBX_FLAG_T] = operand[bit_sel];
    end
  end
endmodule : cbx_bit_unit

// File: bench/cbx_mem_model.sv
// Behavioural data, I/O and program memory facing the execution block
module cbx_mem_model (
  // Data memory side
  input  wire logic        clk,
  input  wire logic        dm_req,
  input  wire logic        dm_we,
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  output logic      [7:0]  dm_rdata,
  // I/O and program memory side
  input  wire logic        io_rd,
  input  wire logic [4:0]  io_addr,
  output logic      [7:0]  io_rdata,
  input  wire logic        pm_req,
  input  wire logic [14:0] pm_addr,
  output logic      [15:0] pm_rdata,
  // Last store seen
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data hashed from address; inverted when unselected so stale data never matches
  assign dm_rdata = dm_addr[7:0] ^ dm_addr[15:8] ^ 8'h5a ^ {8{!dm_req}};
  assign io_rdata = {3'h5, io_addr} ^ {8{!io_rd}};
  assign pm_rdata = {~pm_addr[7:0], pm_addr[7:0]} ^ {16{!pm_req}};
  // Capture each store
  always_ff @(posedge clk) begin
    if (dm_req && dm_we) begin
      wr_addr <= dm_addr;
      wr_data <= dm_wdata;
    end
  end
endmodule : cbx_mem_model

// File: bench/tb_cbx_exec.sv
// Self-checking bench for the execution sequencer
module tb_cbx_exec
  import cbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, cvld = 0, fld = 0, pld = 0, rdy, rv_o, dreq, dwe, iord, iowe, preq;
  cbx_op_e op = OP_NOP;
  cbx_ptr_e ptr = PTR_X, psel = PTR_X;
  cbx_amode_e am = AM_PLAIN;
  logic [7:0] rv = 0, fv = 0, flags, res, dwd, drd, iowd, iord_d, wrd, f;
  logic [7:0] pat [3] = '{8'h00, 8'hff, 8'h04};
  logic [2:0] bsel = 0;
  logic [6:0] off = 7'h7e;
  logic [5:0] disp = 0;
  logic [4:0] ioa;
  logic [14:0] pma;
  logic [15:0] addr = 0, pv = 0, exp_pc = 0, pc, x, y, z, da, wra, prd;
  int num_errors = 0, tests_run = 0, cyc, ticks = 0;
  always #5 clk = ~clk;
  cbx_exec u_dut (.CORE_CLK(clk), .RST_N(rst_n), .CMD_VALID(cvld), .CMD_READY(rdy),
    .CMD_OP(op), .CMD_REG_VAL(rv), .CMD_BIT(bsel), .CMD_OFFSET(off), .CMD_PTR(ptr),
    .CMD_AMODE(am), .CMD_DISP(disp), .CMD_ADDR(addr), .CMD_IO_ADDR(addr[4:0]),
    .PC_LOAD(1'b0), .PC_LOAD_VAL(16'h0000), .FLAGS_LOAD(fld), .FLAGS_LOAD_VAL(fv),
    .PTR_LOAD(pld), .PTR_LOAD_SEL(psel), .PTR_LOAD_VAL(pv), .PC(pc), .FLAGS(flags),
    .X_PTR(x), .Y_PTR(y), .Z_PTR(z), .RES_VALID(rv_o), .RES_VAL(res), .DM_REQ(dreq),
    .DM_WE(dwe), .DM_ADDR(da), .DM_WDATA(dwd), .DM_RDATA(drd), .IO_RD(iord), .IO_WE(iowe),
    .IO_ADDR(ioa), .IO_WDATA(iowd), .IO_RDATA(iord_d), .PM_REQ(preq), .PM_ADDR(pma),
    .PM_RDATA(prd));
  cbx_mem_model u_mem (.clk(clk), .dm_req(dreq), .dm_we(dwe), .dm_addr(da), .dm_wdata(dwd),
    .dm_rdata(drd), .io_rd(iord), .io_addr(ioa), .io_rdata(iord_d), .pm_req(preq),
    .pm_addr(pma), .pm_rdata(prd), .wr_addr(wra), .wr_data(wrd));
  // Compare and count
  task check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // Offer one command at an edge; outputs are read as they stood before each edge
  task issue(input cbx_op_e o, input logic [7:0] v);
    op <= o;
    rv <= v;
    cvld <= 1'b1;
    @(posedge clk);
    cvld <= 1'b0;
    cyc = 1;
    @(posedge clk);
    while (rdy !== 1'b1 && cyc < 8) begin
      @(posedge clk);
      cyc++;
    end
  endtask : issue
  // Preload flags or one pointer from the neighbouring sections
  task load(input logic fl, input logic [7:0] fvv, input cbx_ptr_e s, input logic [15:0] v);
    fld <= fl;
    pld <= !fl;
    fv <= fvv;
    psel <= s;
    pv <= v;
    @(posedge clk);
    fld <= 1'b0;
    pld <= 1'b0;
  endtask : load
  // Branch condition: odd index is the set form, even the clear form
  function automatic logic tk(int i, logic [7:0] g);
    logic [4:0] c;
    c = {g[7], g[3], g[6], g[5], g[2] ^ g[3]};
    return c[(i - 1) / 2] ^ (i % 2 == 0);
  endfunction : tk
  task conclude;
    $display("compares %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) for (int i = 1; i <= 10; i++) begin
      f = pat[p];
      off <= p[0] ? 7'h05 : 7'h7e;
      load(1'b1, f, PTR_X, 16'h0000);
      issue(cbx_op_e'(i), 8'h00);
      exp_pc += tk(i, f) ? (p[0] ? 16'h0006 : 16'hffff) : 16'h0001; // Lands k+1 on
      check(pc, exp_pc);
      check(16'(cyc), tk(i, f) ? 16'h2 : 16'h1);
      check(flags, f);
    end
    $display("branch test finished");
    load(1'b1, 8'h00, PTR_X, 16'h0000);
    issue(OP_SHIFT_LEFT_LOGICAL, 8'h81);
    check({rv_o, res, flags}, 17'h10209);
    issue(OP_SHIFT_RIGHT_ARITH, 8'h81);
    check({res, flags}, 16'hc005);
    issue(OP_NIBBLE_SWAP, 8'h3c);
    check({res, flags}, 16'hc305);
    bsel <= 3'd6;
    issue(OP_FLAG_SET_INDEXED, 8'h00);
    check(flags, 8'h45);
    issue(OP_TRANSFER_TO_BIT, 8'h00);
    check(res, 8'h40);
    addr <= 16'h0005;
    bsel <= 3'd3;
    issue(OP_IO_BIT_SET, 8'h00);
    check({iowe, iowd, 16'(cyc)}, {1'b1, 8'had, 16'h2});
    $display("bit test finished");
    load(1'b0, 8'h00, PTR_Y, 16'hffff);
    ptr <= PTR_Y;
    am <= AM_POSTINC;
    issue(OP_LOAD_INDIRECT, 8'h00);
    check({res, 16'(cyc)}, 24'h5a0002);
    check(y, 16'h0000);
    load(1'b0, 8'h00, PTR_X, 16'h0000);
    ptr <= PTR_X;
    am <= AM_PREDEC;
    issue(OP_STORE_INDIRECT, 8'h77);
    check({wra, wrd, x}, 40'hffff77ffff);
    load(1'b0, 8'h00, PTR_Z, 16'hffff);
    ptr <= PTR_Z;
    am <= AM_DISP;
    disp <= 6'd2;
    issue(OP_LOAD_INDIRECT, 8'h00);
    check({res, z}, 24'h5bffff);
    load(1'b0, 8'h00, PTR_Z, 16'h0003);
    am <= AM_POSTINC;
    issue(OP_PROGRAM_MEM_LOAD, 8'h00);
    check({res, z, 16'(cyc)}, 40'hfe00040003);
    addr <= 16'h1234;
    issue(OP_LOAD_DIRECT, 8'h00);
    check(res, 8'h7c);
    issue(OP_STORE_DIRECT, 8'h99);
    check({wra, wrd}, 24'h123499);
    check({pc, flags}, {exp_pc + 16'h000e, 8'h45});
    $display("transfer test finished");
    conclude();
  end
endmodule : tb_cbx_exec
